// File: design/rwc_pkg.sv
// Shared constants and types for the reset and watchdog control block
package rwc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned MS_PER_S = 1_000;
  localparam int unsigned US_CYCLES_INT = CLK_HZ / US_PER_S;
  localparam logic [4:0] US_CYCLES = 5'(US_CYCLES_INT);

  // Start-up and hold times, as printed
  localparam int unsigned SHORT_DELAY_US = 128;
  localparam int unsigned LONG_DELAY_MS = 96;
  localparam int unsigned WDR_HOLD_US = 2048;

  // Derived cycle counts (exact at 20 MHz)
  localparam int unsigned SHORT_DELAY_CYCLES = SHORT_DELAY_US * US_CYCLES_INT;
  localparam int unsigned LONG_DELAY_CYCLES = LONG_DELAY_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned WDR_HOLD_CYCLES = WDR_HOLD_US * US_CYCLES_INT;

  // Delay counter width, wide enough for the long start-up delay
  localparam int unsigned DLY_W = 21;

  // Free-running timer and watchdog
  localparam int unsigned FTIMER_W = 12;
  localparam int unsigned FTIMER_TICK_BIT = 11;
  localparam int unsigned WDOG_W = 2;

  // I/O addresses
  localparam logic [7:0] ADDR_USB_ADDRESS = 8'h10;
  localparam logic [7:0] ADDR_WDOG_CLEAR = 8'h26;
  localparam logic [7:0] ADDR_PROC_STATUS = 8'hFF;

  // Status and control field positions
  localparam int unsigned STAT_POR_BIT = 4;
  localparam int unsigned STAT_USBR_BIT = 5;
  localparam int unsigned STAT_WDR_BIT = 6;
  localparam logic [7:0] STAT_CAUSE_MASK = 8'h70;
  localparam logic [7:0] STAT_RESET = 8'h10;

  // USB address register field positions and reset value
  localparam int unsigned USB_ADDR_EN_BIT = 7;
  localparam logic [7:0] USB_ADDR_RESET = 8'h00;

  // Reset entry values for the core
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [13:0] PC_RESET = 14'h0000;

  // Sequencer phases
  typedef enum logic [2:0] {
    PH_POR_CHECK,
    PH_SUSPEND,
    PH_START_DELAY,
    PH_RUN,
    PH_WDOG_HOLD
  } rwc_phase_e;

  // I/O request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rwc_io_req_s;

  // USB line levels seen by the sequencer
  typedef struct packed {
    logic usb_minus_line;
    logic usb_plus_line;
    logic bus_reset;
  } rwc_usb_s;

  // State of the sequencer
  typedef struct packed {
    rwc_phase_e phase;
    logic [DLY_W-1:0] dly_cnt;
    logic [7:0] status;
    logic [7:0] usb_address;
    logic [7:0] rdata;
    logic core_hold;
    logic periph_reset;
    logic gpio_force_input;
    logic suspend;
    logic watchdog_reset;
    logic pc_load;
    logic ctx_push_inhibit;
    logic [13:0] pc_value;
    logic [7:0] call_stack_pointer;
    logic [7:0] data_stack_pointer;
  } rwc_seq_s;

  // State of the watchdog
  typedef struct packed {
    logic [4:0] us_cnt;
    logic [FTIMER_W-1:0] ftimer;
    logic [WDOG_W-1:0] wd;
    logic bite;
  } rwc_wdog_s;

endpackage : rwc_pkg

// File: design/rwc_watchdog.sv
`timescale 1ns/1ps
// Free-running microsecond timer with a 2-bit watchdog counter
module rwc_watchdog (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control
  input wire logic run,
  input wire logic clear,
  // Result
  output logic bite
);

  rwc_pkg::rwc_wdog_s s;
  rwc_pkg::rwc_wdog_s next_s;
  logic tick;

  // Next state of timer and counter
  always_comb begin
    next_s = s;
    tick = 1'b0;
    if (s.us_cnt == rwc_pkg::US_CYCLES - 5'h01) begin
      next_s.us_cnt = 5'h00;
      next_s.ftimer = s.ftimer + 12'h001;
    end else begin
      next_s.us_cnt = s.us_cnt + 5'h01;
    end
    // Bit 11 rising gives one tick per 4096 us
    tick = !s.ftimer[rwc_pkg::FTIMER_TICK_BIT] && next_s.ftimer[rwc_pkg::FTIMER_TICK_BIT];
    if (clear || !run) begin
      next_s.wd = 2'h0;
    end else if (tick) begin
      next_s.wd = s.wd + 2'h1;
    end
    // Bite on the MSB going low to high
    next_s.bite = run && !clear && !s.wd[1] && next_s.wd[1];
  end

  // State register; the timer itself never stops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bite = s.bite;

  a_wdog_clear_zero: assert property (@(posedge clock) disable iff (!arst_n) clear |=> s.wd == 2'h0)
    else $error("watchdog counter not cleared by clear port write");

  a_wdog_bite_cause: assert property (@(posedge clock) disable iff (!arst_n)
    bite |-> $past(s.wd) == 2'h1 && s.wd == 2'h2)
    else $error("watchdog bite without MSB rising");

endmodule : rwc_watchdog

// File: design/rwc_reset_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Handle power-on, watchdog and USB bus resets
// - Power-on or watchdog reset restores defaults, clears address
// - Both stack pointers load zero on reset
// - Cause bits 4,5,6 recorded at 0xFF
// - Power-on or watchdog reset fetches from 0x0000
// - Reset entry saves no PC or flags
// - Power-on reset sets power-on flag bit 4
// - Power-on reset forces ports to input
// - Strap high and idle lines enter suspend
// - Start delay chosen by strap and power-on flag
// - Watchdog MSB rising raises reset, sets bit 6
// - Watchdog advances on timer bit 11 tick
// - Any write to 0x26 clears watchdog
// - Watchdog reset held 2.048 ms, then run
// - USB transmitter off until address enable set
// - Hardware and bus reset clear USB address
module rwc_reset_ctrl #(
  parameter int unsigned LONG_DELAY_CYCLES = rwc_pkg::LONG_DELAY_CYCLES,
  parameter int unsigned WDR_HOLD_CYCLES = rwc_pkg::WDR_HOLD_CYCLES
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic arst_n,
  // Core I/O access
  input wire rwc_pkg::rwc_io_req_s io_req,
  output logic [7:0] io_rdata,
  // Strap and USB lines
  input wire logic wake_strap,
  input wire rwc_pkg::rwc_usb_s usb,
  // Core control
  output logic core_hold,
  output logic pc_load,
  output logic [13:0] pc_value,
  output logic ctx_push_inhibit,
  output logic [7:0] call_stack_pointer,
  output logic [7:0] data_stack_pointer,
  // System control
  output logic periph_reset,
  output logic gpio_force_input,
  output logic suspend,
  output logic watchdog_reset,
  output logic power_on_flag,
  output logic usb_tx_enable,
  output logic [7:0] usb_address
);

  localparam logic [rwc_pkg::DLY_W-1:0] SHORT_LOAD = rwc_pkg::DLY_W'(rwc_pkg::SHORT_DELAY_CYCLES - 1);
  localparam logic [rwc_pkg::DLY_W-1:0] LONG_LOAD = rwc_pkg::DLY_W'(LONG_DELAY_CYCLES - 1);
  localparam logic [rwc_pkg::DLY_W-1:0] WDR_LOAD = rwc_pkg::DLY_W'(WDR_HOLD_CYCLES - 1);

  rwc_pkg::rwc_seq_s s;
  rwc_pkg::rwc_seq_s next_s;
  logic wdog_clear;
  logic wdog_bite;
  logic lines_idle;
  logic wr_status;
  logic wr_usb_addr;

  // Start-up delay: strap high always short, else flag picks long
  function automatic logic [rwc_pkg::DLY_W-1:0] delay_pick(input logic strap, input logic por);
    if (!strap && por) begin
      delay_pick = LONG_LOAD;
    end else begin
      delay_pick = SHORT_LOAD;
    end
  endfunction : delay_pick

  // Read data for an I/O address; unowned and write-only read zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input rwc_pkg::rwc_seq_s st);
    case (addr)
      rwc_pkg::ADDR_PROC_STATUS: read_mux = st.status;
      rwc_pkg::ADDR_USB_ADDRESS: read_mux = st.usb_address;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Decodes of the core's I/O strobes
  assign wdog_clear = io_req.wr && io_req.addr == rwc_pkg::ADDR_WDOG_CLEAR;
  assign wr_status = io_req.wr && io_req.addr == rwc_pkg::ADDR_PROC_STATUS;
  assign wr_usb_addr = io_req.wr && io_req.addr == rwc_pkg::ADDR_USB_ADDRESS;
  // Idle is J: minus line high, plus line low
  assign lines_idle = usb.usb_minus_line && !usb.usb_plus_line;

  // Watchdog runs only while the core executes
  rwc_watchdog u_watchdog (
    .clock(clock),
    .arst_n(arst_n),
    .run(s.phase == rwc_pkg::PH_RUN),
    .clear(wdog_clear),
    .bite(wdog_bite)
  );

  // Sequencer next state
  always_comb begin
    next_s = s;
    next_s.pc_load = 1'b0;
    next_s.rdata = io_req.rd ? read_mux(io_req.addr, s) : 8'h00;

    // Firmware writes; hardware sets below take priority
    if (s.phase == rwc_pkg::PH_RUN) begin
      if (wr_status) begin
        next_s.status = io_req.wdata;
      end
      if (wr_usb_addr) begin
        next_s.usb_address = io_req.wdata;
      end
    end

    case (s.phase)
      // Strap and idle lines decide between suspend and a timed start
      rwc_pkg::PH_POR_CHECK: begin
        if (wake_strap && lines_idle) begin
          next_s.phase = rwc_pkg::PH_SUSPEND;
          next_s.suspend = 1'b1;
        end else begin
          next_s.phase = rwc_pkg::PH_START_DELAY;
          next_s.dly_cnt = delay_pick(wake_strap, s.status[rwc_pkg::STAT_POR_BIT]);
        end
      end
      // Wait for K, SE0 or bus reset, i.e. minus line low
      rwc_pkg::PH_SUSPEND: begin
        if (!usb.usb_minus_line) begin
          next_s.phase = rwc_pkg::PH_START_DELAY;
          next_s.suspend = 1'b0;
          next_s.dly_cnt = delay_pick(wake_strap, s.status[rwc_pkg::STAT_POR_BIT]);
        end
      end
      // Hold the core until the oscillator or supply settles
      rwc_pkg::PH_START_DELAY: begin
        if (s.dly_cnt == '0) begin
          next_s.phase = rwc_pkg::PH_RUN;
          next_s.gpio_force_input = 1'b0;
          next_s.pc_load = 1'b1;
        end else begin
          next_s.dly_cnt = s.dly_cnt - 1'b1;
        end
      end
      // Normal execution; watchdog bite restarts the core
      rwc_pkg::PH_RUN: begin
        if (wdog_bite) begin
          next_s.phase = rwc_pkg::PH_WDOG_HOLD;
          next_s.dly_cnt = WDR_LOAD;
          next_s.watchdog_reset = 1'b1;
          // Non-cause bits return to defaults, cause bits persist
          next_s.status = (next_s.status & rwc_pkg::STAT_CAUSE_MASK)
            | (rwc_pkg::STAT_RESET & ~rwc_pkg::STAT_CAUSE_MASK);
          next_s.status[rwc_pkg::STAT_WDR_BIT] = 1'b1;
          next_s.usb_address = rwc_pkg::USB_ADDR_RESET;
        end
      end
      // Watchdog reset lasts exactly the hold count
      rwc_pkg::PH_WDOG_HOLD: begin
        if (s.dly_cnt == '0) begin
          next_s.phase = rwc_pkg::PH_RUN;
          next_s.watchdog_reset = 1'b0;
          next_s.pc_load = 1'b1;
        end else begin
          next_s.dly_cnt = s.dly_cnt - 1'b1;
        end
      end
      default: begin
        next_s.phase = rwc_pkg::PH_POR_CHECK;
      end
    endcase

    // USB bus reset is a soft reset: no core restart
    if (usb.bus_reset) begin
      next_s.status[rwc_pkg::STAT_USBR_BIT] = 1'b1;
      next_s.usb_address = rwc_pkg::USB_ADDR_RESET;
    end

    // Core held outside run; peripherals cleared with it or on bus reset
    next_s.core_hold = next_s.phase != rwc_pkg::PH_RUN;
    next_s.periph_reset = next_s.core_hold || usb.bus_reset;
    // No context push while held or on the entry cycle
    next_s.ctx_push_inhibit = next_s.core_hold || next_s.pc_load;
    // Stack pointers and PC are reloaded while held
    if (next_s.core_hold) begin
      next_s.call_stack_pointer = rwc_pkg::SP_RESET;
      next_s.data_stack_pointer = rwc_pkg::SP_RESET;
      next_s.pc_value = rwc_pkg::PC_RESET;
    end
  end

  // State register; asynchronous reset is the power-on reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s.phase <= rwc_pkg::PH_POR_CHECK;
      s.dly_cnt <= '0;
      s.status <= rwc_pkg::STAT_RESET;
      s.usb_address <= rwc_pkg::USB_ADDR_RESET;
      s.rdata <= 8'h00;
      s.core_hold <= 1'b1;
      s.periph_reset <= 1'b1;
      s.gpio_force_input <= 1'b1;
      s.suspend <= 1'b0;
      s.watchdog_reset <= 1'b0;
      s.pc_load <= 1'b0;
      s.ctx_push_inhibit <= 1'b1;
      s.pc_value <= rwc_pkg::PC_RESET;
      s.call_stack_pointer <= rwc_pkg::SP_RESET;
      s.data_stack_pointer <= rwc_pkg::SP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign io_rdata = s.rdata;
  assign core_hold = s.core_hold;
  assign pc_load = s.pc_load;
  assign pc_value = s.pc_value;
  assign ctx_push_inhibit = s.ctx_push_inhibit;
  assign call_stack_pointer = s.call_stack_pointer;
  assign data_stack_pointer = s.data_stack_pointer;
  assign periph_reset = s.periph_reset;
  assign gpio_force_input = s.gpio_force_input;
  assign suspend = s.suspend;
  assign watchdog_reset = s.watchdog_reset;
  assign power_on_flag = s.status[rwc_pkg::STAT_POR_BIT];
  assign usb_address = s.usb_address;
  // Transmitter gated by the address enable bit, which any reset clears
  assign usb_tx_enable = s.usb_address[rwc_pkg::USB_ADDR_EN_BIT];

  // Helper: phase one cycle back
  rwc_pkg::rwc_phase_e prev_phase;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_phase <= rwc_pkg::PH_POR_CHECK;
    end else begin
      prev_phase <= s.phase;
    end
  end

  // Bite leads to hold with flag set and address cleared
  sequence bite_seen;
    wdog_bite && s.phase == rwc_pkg::PH_RUN;
  endsequence

  sequence wdr_entered;
    s.phase == rwc_pkg::PH_WDOG_HOLD && s.status[rwc_pkg::STAT_WDR_BIT] && s.usb_address == 8'h00;
  endsequence

  a_wdog_entry_state: assert property (@(posedge clock) disable iff (!arst_n) bite_seen |=> wdr_entered)
    else $error("watchdog bite did not enter hold with flag set");

  a_wdog_hold_min: assert property (@(posedge clock) disable iff (!arst_n)
    bite_seen |=> (core_hold && watchdog_reset) [*8])
    else $error("watchdog reset released too early");

  a_wdog_load_len: assert property (@(posedge clock) disable iff (!arst_n)
    bite_seen |=> s.dly_cnt == WDR_LOAD)
    else $error("watchdog hold count wrong");

  a_release_pc_zero: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(core_hold) |-> pc_load && pc_value == 14'h0000 && call_stack_pointer == 8'h00
      && data_stack_pointer == 8'h00)
    else $error("core released without zero entry state");

  a_no_ctx_push: assert property (@(posedge clock) disable iff (!arst_n)
    (core_hold || pc_load) |-> ctx_push_inhibit)
    else $error("context push allowed during reset entry");

  a_usb_reset_clear: assert property (@(posedge clock) disable iff (!arst_n)
    usb.bus_reset |=> usb_address == 8'h00 && !usb_tx_enable && s.status[rwc_pkg::STAT_USBR_BIT]
      && periph_reset)
    else $error("bus reset did not clear address or set flag");

  a_suspend_entry: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_POR_CHECK && wake_strap && lines_idle |=> suspend && core_hold)
    else $error("strap high with idle lines did not suspend");

  a_suspend_exit: assert property (@(posedge clock) disable iff (!arst_n)
    suspend && !usb.usb_minus_line |=> !suspend && s.phase == rwc_pkg::PH_START_DELAY
      && s.dly_cnt == (($past(wake_strap) || !power_on_flag) ? SHORT_LOAD : LONG_LOAD))
    else $error("suspend not left on resume or reset signalling");

  a_delay_select: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_START_DELAY && prev_phase != rwc_pkg::PH_START_DELAY |->
      s.dly_cnt == (($past(wake_strap) || !power_on_flag) ? SHORT_LOAD : LONG_LOAD))
    else $error("start-up delay value wrong");

  a_gpio_input_hold: assert property (@(posedge clock) disable iff (!arst_n)
    (s.phase == rwc_pkg::PH_SUSPEND || s.phase == rwc_pkg::PH_START_DELAY) |-> gpio_force_input)
    else $error("ports not forced to input before release");

  a_cause_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    $past(s.status[rwc_pkg::STAT_POR_BIT]) && !$past(wr_status && s.phase == rwc_pkg::PH_RUN)
      |-> power_on_flag)
    else $error("power-on flag lost without firmware write");

  // Reload values and peripheral reset stand for every held cycle
  a_hold_reloads: assert property (@(posedge clock) disable iff (!arst_n)
    core_hold |-> call_stack_pointer == 8'h00 && data_stack_pointer == 8'h00 && pc_value == 14'h0000)
    else $error("stack pointers or entry address not reloaded while held");

  a_hold_periph_reset: assert property (@(posedge clock) disable iff (!arst_n)
    core_hold |-> periph_reset)
    else $error("peripherals not reset while core held");

  a_wdr_tx_off: assert property (@(posedge clock) disable iff (!arst_n)
    watchdog_reset |-> !usb_tx_enable && usb_address == 8'h00)
    else $error("transmitter enabled during watchdog reset");

  a_wdog_no_gpio: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_WDOG_HOLD |-> !gpio_force_input)
    else $error("watchdog reset forced ports to input");

  a_bus_reset_soft: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_RUN && usb.bus_reset && !wdog_bite |=> !core_hold && !pc_load)
    else $error("bus reset restarted the core");

  // Counts fall by one per cycle in both timed phases
  a_hold_count_down: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_WDOG_HOLD && s.dly_cnt != '0 |=> s.phase == rwc_pkg::PH_WDOG_HOLD
      && s.dly_cnt == $past(s.dly_cnt) - 1'b1)
    else $error("watchdog hold count did not step down");

  a_start_count_down: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_START_DELAY && s.dly_cnt != '0 |=> s.phase == rwc_pkg::PH_START_DELAY
      && s.dly_cnt == $past(s.dly_cnt) - 1'b1)
    else $error("start-up delay count did not step down");

  // Last hold cycle and the release that follows it
  sequence hold_done;
    s.phase == rwc_pkg::PH_WDOG_HOLD && s.dly_cnt == '0;
  endsequence

  sequence core_released;
    !core_hold && pc_load && !watchdog_reset && s.phase == rwc_pkg::PH_RUN;
  endsequence

  a_wdog_release: assert property (@(posedge clock) disable iff (!arst_n)
    hold_done |=> core_released)
    else $error("core not released after watchdog hold");

  a_cause_bits_kept: assert property (@(posedge clock) disable iff (!arst_n)
    !$past(wr_status && s.phase == rwc_pkg::PH_RUN) |->
      (($past(s.status) & ~s.status) & rwc_pkg::STAT_CAUSE_MASK) == 8'h00)
    else $error("reset cause bit lost without firmware write");

  a_status_write: assert property (@(posedge clock) disable iff (!arst_n)
    s.phase == rwc_pkg::PH_RUN && wr_status && !usb.bus_reset && !wdog_bite
      |=> s.status == $past(io_req.wdata))
    else $error("firmware write to status did not land");

  a_status_read: assert property (@(posedge clock) disable iff (!arst_n)
    io_req.rd && io_req.addr == rwc_pkg::ADDR_PROC_STATUS |=> io_rdata == $past(s.status))
    else $error("status read returned wrong value");

  a_held_addr_kept: assert property (@(posedge clock) disable iff (!arst_n)
    core_hold && !usb.bus_reset |=> $stable(usb_address))
    else $error("address register changed while core held");

endmodule : rwc_reset_ctrl

// File: tb/rwc_usb_line_model.sv
`timescale 1ns/1ps
// Bus-side model of the USB lines as seen at the device pins
module rwc_usb_line_model (
  // Line state request from the bench
  input wire logic [1:0] line_mode,
  input wire logic bus_reset_req,
  // Line levels toward the block
  output rwc_pkg::rwc_usb_s usb
);
  // 0 idle J, 1 resume K, 2 and 3 SE0; D+ pull-down keeps SE0 low
  always_comb begin
    usb.usb_minus_line = (line_mode == 2'h0);
    usb.usb_plus_line = (line_mode == 2'h1);
    usb.bus_reset = bus_reset_req;
  end
endmodule : rwc_usb_line_model

// File: tb/testbench.sv
`timescale 1ns/1ps
// Sequence tests for the reset and watchdog control block
module testbench;
  localparam int LONG_CYC = 200;
  localparam int HOLD_CYC = 50;
  localparam int TICK_CYC = 81920;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wake_strap = 1'b0;
  logic [1:0] line_mode = 2'h0;
  logic bus_reset_req = 1'b0;
  rwc_pkg::rwc_io_req_s io_req = '0;
  rwc_pkg::rwc_usb_s usb;
  logic [7:0] io_rdata;
  logic core_hold, pc_load, ctx_push_inhibit, periph_reset, gpio_force_input;
  logic suspend, watchdog_reset, power_on_flag, usb_tx_enable;
  logic [13:0] pc_value;
  logic [7:0] call_stack_pointer, data_stack_pointer, usb_address, rd;
  int err_count = 0;
  int checks = 0;
  int n;

  // Clock at 20 MHz
  always #25 clock = ~clock;

  rwc_usb_line_model u_rwc_usb_line_model (.line_mode(line_mode), .bus_reset_req(bus_reset_req), .usb(usb));

  // Shortened long delay and hold keep the run short
  rwc_reset_ctrl #(.LONG_DELAY_CYCLES(LONG_CYC), .WDR_HOLD_CYCLES(HOLD_CYC)) u_rwc_reset_ctrl (
    .clock(clock), .arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata), .wake_strap(wake_strap),
    .usb(usb), .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value),
    .ctx_push_inhibit(ctx_push_inhibit), .call_stack_pointer(call_stack_pointer),
    .data_stack_pointer(data_stack_pointer), .periph_reset(periph_reset),
    .gpio_force_input(gpio_force_input), .suspend(suspend), .watchdog_reset(watchdog_reset),
    .power_on_flag(power_on_flag), .usb_tx_enable(usb_tx_enable), .usb_address(usb_address)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Picks the output a wait loop watches
  function automatic logic pick(input int sel);
    case (sel)
      0: return core_hold;
      1: return watchdog_reset;
      default: return suspend;
    endcase
  endfunction : pick

  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_for(input int sel, input logic lvl, input int bound, output int cyc);
    cyc = 0;
    while (pick(sel) !== lvl && cyc < bound) begin
      @(negedge clock);
      cyc++;
    end
    if (pick(sel) !== lvl) begin
      err_count++;
      $display("unexpected at %0t: wait bound %0h reached", $time, bound);
      report_and_stop();
    end
  endtask : wait_for

  // One-cycle write strobe
  task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    io_req = '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(negedge clock);
    io_req.wr = 1'b0;
  endtask : io_write

  // Read data stands the cycle after the strobe edge
  task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    io_req = '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clock);
    io_req.rd = 1'b0;
    data = io_rdata;
  endtask : io_read

  // Power-on reset with the values held during it
  task automatic do_reset();
    @(negedge clock);
    arst_n = 1'b0;
    repeat (10) @(negedge clock);
    check({core_hold, periph_reset, gpio_force_input, ctx_push_inhibit}, 16'h000F);
    check({power_on_flag, suspend, watchdog_reset}, 16'h0004);
    check({call_stack_pointer, data_stack_pointer}, 16'h0000);
    check(usb_address, 16'h0000);
    arst_n = 1'b1;
  endtask : do_reset

  initial begin
    // Strap low after power-on: long start delay
    do_reset();
    wait_for(0, 1'b0, 1000, n);
    check(n >= LONG_CYC && n <= LONG_CYC + 3, 16'h0001);
    check({pc_load, ctx_push_inhibit, pc_value}, 16'hC000);
    @(negedge clock);
    check({pc_load, ctx_push_inhibit, gpio_force_input}, 16'h0000);
    io_read(8'hFF, rd);
    check(rd, 16'h0010);
    $display("test long start done");
    // Address register, enable bit and unmapped reads
    io_write(8'h10, 8'h85);
    check(usb_tx_enable, 16'h0001);
    io_read(8'h10, rd);
    check(rd, 16'h0085);
    io_read(8'h26, rd);
    check(rd, 16'h0000);
    io_read(8'h3C, rd);
    check(rd, 16'h0000);
    // Bus reset: cause bit, address cleared, core keeps running
    @(negedge clock);
    bus_reset_req = 1'b1;
    @(negedge clock);
    bus_reset_req = 1'b0;
    check({periph_reset, core_hold, usb_tx_enable}, 16'h0004);
    check(usb_address, 16'h0000);
    @(negedge clock);
    check(periph_reset, 16'h0000);
    io_read(8'hFF, rd);
    check(rd, 16'h0030);
    io_write(8'hFF, 8'h00);
    io_read(8'hFF, rd);
    check(rd, 16'h0000);
    $display("test bus reset done");
    // Watchdog left unserviced after one clear
    io_write(8'h10, 8'h81);
    io_write(8'h26, 8'h5A);
    wait_for(1, 1'b1, 2 * TICK_CYC + 10, n);
    check(n >= TICK_CYC - 2 && n <= 2 * TICK_CYC + 2, 16'h0001);
    check({core_hold, usb_tx_enable, usb_address}, 16'h0200);
    wait_for(0, 1'b0, HOLD_CYC + 10, n);
    check(n >= HOLD_CYC - 2 && n <= HOLD_CYC + 2, 16'h0001);
    check({pc_load, pc_value}, 16'h4000);
    check({gpio_force_input, call_stack_pointer}, 16'h0000);
    io_read(8'hFF, rd);
    check(rd, 16'h0040);
    $display("test watchdog done");
    // Strap high on idle lines: suspend until resume, then short delay
    wake_strap = 1'b1;
    line_mode = 2'h0;
    do_reset();
    wait_for(2, 1'b1, 5, n);
    repeat (300) @(negedge clock);
    check({suspend, core_hold, gpio_force_input}, 16'h0007);
    line_mode = 2'h1;
    wait_for(0, 1'b0, 3000, n);
    check(n >= 2560 && n <= 2566, 16'h0001);
    check(suspend, 16'h0000);
    io_read(8'hFF, rd);
    check(rd, 16'h0010);
    $display("test suspend done");
    // Strap dropped in suspend, SE0 wakes: flag still set picks long delay
    line_mode = 2'h0;
    do_reset();
    wait_for(2, 1'b1, 5, n);
    wake_strap = 1'b0;
    line_mode = 2'h2;
    wait_for(0, 1'b0, 1000, n);
    check(n >= LONG_CYC && n <= LONG_CYC + 3, 16'h0001);
    check({suspend, gpio_force_input}, 16'h0000);
    $display("test wake on reset signalling done");
    report_and_stop();
  end
endmodule : testbench
